// File: logic/cps_pkg.sv
package cps_pkg;

  localparam int PC_W        = 32;
  localparam int REG_W       = 5;
  localparam int NUM_REGS    = 32;
  localparam int TAG_W       = 4;
  localparam int CQ_DEPTH    = 16;
  localparam int IQ_DEPTH    = 8;
  localparam int IQSEL_W     = 2;
  localparam int NUM_ISSQ    = 4;
  localparam int UNIT_W      = 3;
  localparam int HINT_W      = 5;
  localparam int BHT_IDX_W   = 6;
  localparam int BHT_N       = 64;
  localparam int PC_IDX_LSB  = 2;

  localparam logic [PC_W-1:0] INSTR_BYTES = 32'h0000_0004;
  localparam logic [1:0]      BHT_RESET   = 2'h1;
  localparam logic [1:0]      BHT_MAX     = 2'h3;
  localparam logic [1:0]      BHT_MIN     = 2'h0;
  localparam int              BHT_DIR_BIT = 1;

  // One fetched instruction as the fetch path delivers it
  typedef struct packed {
    logic [PC_W-1:0]    pc;
    logic [PC_W-1:0]    target;
    logic               isBranch;
    logic [HINT_W-1:0]  branchOptions;
    logic [IQSEL_W-1:0] issueSel;
    logic [REG_W-1:0]   srcReg;
    logic               hasSrc;
    logic [REG_W-1:0]   dstReg;
    logic               hasDst;
  } cps_instr_t;

  // Renamed instruction handed to an issue queue
  typedef struct packed {
    cps_instr_t         instr;
    logic [TAG_W-1:0]   tag;
    logic               srcRenamed;
    logic [TAG_W-1:0]   srcTag;
    logic               predTaken;
  } cps_disp_t;

  typedef struct packed {
    logic [TAG_W-1:0]   tag;
    logic [UNIT_W-1:0]  unit;
    logic               srcRenamed;
    logic [TAG_W-1:0]   srcTag;
  } cps_issue_t;

  typedef struct packed {
    logic [TAG_W-1:0]   tag;
    logic [UNIT_W-1:0]  unit;
    logic               srcFromRename;
    logic [TAG_W-1:0]   srcTag;
  } cps_exec_t;

  typedef struct packed {
    logic [TAG_W-1:0]   tag;
    logic               isBranch;
    logic               taken;
    logic [PC_W-1:0]    pc;
    logic [PC_W-1:0]    target;
    logic               excp;
  } cps_finish_t;

endpackage

// File: logic/cps_cmpl_queue.sv
`timescale 1ns/10ps
`default_nettype none
module cps_cmpl_queue (
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire logic                         alloc,
  input  wire logic                         finishValid,
  input  wire logic [cps_pkg::TAG_W-1:0]    finishTag,
  input  wire logic                         finishFlush,
  input  wire logic                         markValid,
  input  wire logic [cps_pkg::TAG_W-1:0]    markTag,
  output logic      [cps_pkg::TAG_W-1:0]    headTag_q,
  output logic      [cps_pkg::TAG_W-1:0]    tailTag_q,
  output logic      [cps_pkg::TAG_W:0]      count_q,
  output logic      [cps_pkg::CQ_DEPTH-1:0] wrongPath_q,
  output logic      [1:0]                   retireCnt_q,
  output logic      [cps_pkg::TAG_W-1:0]    retireTag0_q,
  output logic      [cps_pkg::TAG_W-1:0]    retireTag1_q,
  output logic                              purge_q
);
  localparam int TW = cps_pkg::TAG_W;
  localparam int D  = cps_pkg::CQ_DEPTH;

  logic [TW-1:0] headTag_d, tailTag_d, head1, retireTag0_d, retireTag1_d;
  logic [TW:0]   count_d;
  logic [D-1:0]  finished_q, finished_d, flushAfter_q, flushAfter_d;
  logic [D-1:0]  wrongPath_d;
  logic [1:0]    retireCnt_d;
  logic          purge_d, r0, r1;
  logic [TW-1:0] markAge, age;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    head1 = headTag_q + 1'b1;
    // Only the two oldest entries may leave, and only once finished
    r0 = (count_q != '0) && finished_q[headTag_q];
    r1 = r0 && !flushAfter_q[headTag_q] && (count_q > 1)
         && finished_q[head1];
    purge_d = (r0 && flushAfter_q[headTag_q])
              || (r1 && flushAfter_q[head1]);
    retireCnt_d  = {1'b0, r0} + {1'b0, r1};
    retireTag0_d = headTag_q;
    retireTag1_d = head1;
    finished_d   = finished_q;
    flushAfter_d = flushAfter_q;
    wrongPath_d  = wrongPath_q;
    headTag_d    = headTag_q + TW'(retireCnt_d);
    tailTag_d    = tailTag_q;
    count_d      = count_q - (TW+1)'(retireCnt_d);
    markAge      = markTag - headTag_q;
    if (finishValid) begin
      finished_d[finishTag]   = 1'b1;
      flushAfter_d[finishTag] = finishFlush;
    end
    for (int i = 0; i < D; i++) begin
      age = TW'(i) - headTag_q;
      if (markValid && (age > markAge) && ({1'b0, age} < count_q))
        wrongPath_d[i] = 1'b1;
    end
    if (alloc) begin
      finished_d[tailTag_q]   = 1'b0;
      flushAfter_d[tailTag_q] = 1'b0;
      wrongPath_d[tailTag_q]  = 1'b0;
      tailTag_d = tailTag_q + 1'b1;
      count_d   = count_d + 1'b1;
    end
    // Purge empties the queue; anything allocated this cycle is younger
    if (purge_d) begin
      headTag_d    = '0;
      tailTag_d    = '0;
      count_d      = '0;
      finished_d   = '0;
      flushAfter_d = '0;
      wrongPath_d  = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      headTag_q    <= '0;
      tailTag_q    <= '0;
      count_q      <= '0;
      finished_q   <= '0;
      flushAfter_q <= '0;
      wrongPath_q  <= '0;
      retireCnt_q  <= '0;
      retireTag0_q <= '0;
      retireTag1_q <= '0;
      purge_q      <= 1'b0;
    end else begin
      headTag_q    <= headTag_d;
      tailTag_q    <= tailTag_d;
      count_q      <= count_d;
      finished_q   <= finished_d;
      flushAfter_q <= flushAfter_d;
      wrongPath_q  <= wrongPath_d;
      retireCnt_q  <= retireCnt_d;
      retireTag0_q <= retireTag0_d;
      retireTag1_q <= retireTag1_d;
      purge_q      <= purge_d;
    end
  end
endmodule
`default_nettype wire

// File: logic/cps_pipeline_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module cps_pipeline_sequencer #(
  parameter int IQ_DEPTH = cps_pkg::IQ_DEPTH
) (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic                          branchPredictEnable,
  input  wire logic                          fetchValid,
  input  wire cps_pkg::cps_instr_t           fetchInstr,
  output logic                               fetchReady_q,
  output logic                               redirectValid_q,
  output logic      [cps_pkg::PC_W-1:0]      redirectPc_q,
  input  wire logic [cps_pkg::NUM_ISSQ-1:0]  issueQueueFree,
  output logic                               dispValid_q,
  output cps_pkg::cps_disp_t                 disp_q,
  input  wire logic                          issueValid,
  input  wire cps_pkg::cps_issue_t           issueReq,
  output logic                               execValid_q,
  output cps_pkg::cps_exec_t                 exec_q,
  input  wire logic                          finishValid,
  input  wire cps_pkg::cps_finish_t          finishReq,
  output logic      [1:0]                    retireCnt,
  output logic      [cps_pkg::TAG_W-1:0]     retireTag0,
  output logic      [cps_pkg::TAG_W-1:0]     retireTag1,
  output logic                               purge
);
  localparam int TW  = cps_pkg::TAG_W;
  localparam int IAW = $clog2(IQ_DEPTH);

  logic [TW-1:0]  cqHead, cqTail;
  logic [TW:0]    cqCount;
  logic [cps_pkg::CQ_DEPTH-1:0] cqWrong;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction queue between fetch and decode
  cps_pkg::cps_instr_t iqMem_q [IQ_DEPTH];
  cps_pkg::cps_instr_t iqMem_d [IQ_DEPTH];
  cps_pkg::cps_instr_t head;
  logic [IAW-1:0] iqHead_q, iqHead_d, iqTail_q, iqTail_d;
  logic [IAW:0]   iqCount_q, iqCount_d;
  logic           fetchReady_d, doFetch, flushIq, keepIq;

  // Rename map, live rename results, prediction state
  logic [cps_pkg::NUM_REGS-1:0] mapValid_q, mapValid_d;
  logic [TW-1:0] mapTag_q [cps_pkg::NUM_REGS];
  logic [TW-1:0] mapTag_d [cps_pkg::NUM_REGS];
  logic [cps_pkg::CQ_DEPTH-1:0] live_q, live_d, predTbl_q, predTbl_d;
  logic [1:0] bht_q [cps_pkg::BHT_N];
  logic [1:0] bht_d [cps_pkg::BHT_N];
  logic [cps_pkg::BHT_IDX_W-1:0] bhtIdx, updIdx;

  logic          mispPend_q, mispPend_d, canDisp, predTaken, mispNow;
  logic [TW-1:0] mispTag_q, mispTag_d;
  logic          dispValid_d, redirectValid_d, execValid_d;
  logic [cps_pkg::PC_W-1:0] redirectPc_d;
  cps_pkg::cps_disp_t disp_d;
  cps_pkg::cps_exec_t exec_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    head   = iqMem_q[iqHead_q];
    bhtIdx = head.pc[cps_pkg::PC_IDX_LSB +: cps_pkg::BHT_IDX_W];
    updIdx = finishReq.pc[cps_pkg::PC_IDX_LSB +: cps_pkg::BHT_IDX_W];
    // Direction comes only from the dynamic table; hint bits are dropped
    predTaken = branchPredictEnable && head.isBranch
                && bht_q[bhtIdx][cps_pkg::BHT_DIR_BIT];
    // Resolution; a wrong-path branch or one younger than a pending
    // mispredict cannot redirect
    mispNow = finishValid && finishReq.isBranch && !cqWrong[finishReq.tag]
              && (finishReq.taken != predTbl_q[finishReq.tag])
              && (!mispPend_q
                  || ((finishReq.tag - cqHead) < (mispTag_q - cqHead)));
    // Room in both the chosen issue queue and completion_queue
    canDisp = (iqCount_q != '0) && issueQueueFree[head.issueSel]
              && (cqCount < (TW+1)'(cps_pkg::CQ_DEPTH))
              && !mispPend_q && !mispNow && !purge;
    // A purge raised by the pending mispredict itself must not drop the
    // right-path instructions fetched after the redirect
    keepIq  = mispPend_q && ((retireCnt == 2'h2 ? retireTag1 : retireTag0)
                             == mispTag_q);
    flushIq = mispNow || (purge && !keepIq) || (canDisp && predTaken);
    // Data seen during the redirect pulse is still the old path
    doFetch = fetchValid && fetchReady_q && !redirectValid_q;

    iqMem_d   = iqMem_q;
    iqHead_d  = iqHead_q;
    iqTail_d  = iqTail_q;
    iqCount_d = iqCount_q;
    if (flushIq) begin
      iqHead_d  = '0;
      iqTail_d  = '0;
      iqCount_d = '0;
    end else begin
      if (doFetch) begin
        iqMem_d[iqTail_q] = fetchInstr;
        iqTail_d = iqTail_q + 1'b1;
      end
      if (canDisp)
        iqHead_d = iqHead_q + 1'b1;
      iqCount_d = iqCount_q + {{IAW{1'b0}}, doFetch}
                  - {{IAW{1'b0}}, canDisp};
    end
    fetchReady_d = iqCount_d < (IAW+1)'(IQ_DEPTH);

    // Dispatch: rename and allocate in one event
    disp_d.instr      = head;
    disp_d.tag        = cqTail;
    disp_d.srcRenamed = head.hasSrc && mapValid_q[head.srcReg];
    disp_d.srcTag     = mapTag_q[head.srcReg];
    disp_d.predTaken  = predTaken;
    dispValid_d       = canDisp;

    mapValid_d = mapValid_q;
    mapTag_d   = mapTag_q;
    live_d     = live_q;
    predTbl_d  = predTbl_q;
    // A retired producer's value now sits in the register file
    for (int r = 0; r < cps_pkg::NUM_REGS; r++) begin
      if ((retireCnt != 2'h0 && mapTag_q[r] == retireTag0)
          || (retireCnt == 2'h2 && mapTag_q[r] == retireTag1))
        mapValid_d[r] = 1'b0;
    end
    if (retireCnt != 2'h0)
      live_d[retireTag0] = 1'b0;
    if (retireCnt == 2'h2)
      live_d[retireTag1] = 1'b0;
    if (finishValid && !cqWrong[finishReq.tag])
      live_d[finishReq.tag] = 1'b1;
    if (canDisp) begin
      predTbl_d[cqTail] = predTaken;
      live_d[cqTail]    = 1'b0;
      if (head.hasDst) begin
        mapValid_d[head.dstReg] = 1'b1;
        mapTag_d[head.dstReg]   = cqTail;
      end
    end
    // Everything in flight is gone after a purge
    if (purge) begin
      mapValid_d = '0;
      live_d     = '0;
    end

    bht_d = bht_q;
    if (finishValid && finishReq.isBranch && !cqWrong[finishReq.tag]) begin
      if (finishReq.taken && bht_q[updIdx] != cps_pkg::BHT_MAX)
        bht_d[updIdx] = bht_q[updIdx] + 2'h1;
      else if (!finishReq.taken && bht_q[updIdx] != cps_pkg::BHT_MIN)
        bht_d[updIdx] = bht_q[updIdx] - 2'h1;
    end

    mispPend_d = mispPend_q;
    mispTag_d  = mispTag_q;
    if (mispNow) begin
      mispPend_d = 1'b1;
      mispTag_d  = finishReq.tag;
    end
    if (purge)
      mispPend_d = 1'b0;

    redirectValid_d = 1'b0;
    redirectPc_d    = redirectPc_q;
    if (mispNow) begin
      redirectValid_d = 1'b1;
      redirectPc_d    = finishReq.taken ? finishReq.target
                        : finishReq.pc + cps_pkg::INSTR_BYTES;
    end else if (canDisp && predTaken) begin
      redirectValid_d = 1'b1;
      redirectPc_d    = head.target;
    end

    // Issue: live rename result or register file, wrong path squashed
    exec_d.tag           = issueReq.tag;
    exec_d.unit          = issueReq.unit;
    exec_d.srcTag        = issueReq.srcTag;
    exec_d.srcFromRename = issueReq.srcRenamed
                           && live_q[issueReq.srcTag];
    execValid_d = issueValid && !cqWrong[issueReq.tag] && !purge;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      iqMem_q         <= '{default: '0};
      iqHead_q        <= '0;
      iqTail_q        <= '0;
      iqCount_q       <= '0;
      fetchReady_q    <= 1'b0;
      mapValid_q      <= '0;
      mapTag_q        <= '{default: '0};
      live_q          <= '0;
      predTbl_q       <= '0;
      bht_q           <= '{default: cps_pkg::BHT_RESET};
      mispPend_q      <= 1'b0;
      mispTag_q       <= '0;
      dispValid_q     <= 1'b0;
      disp_q          <= '0;
      redirectValid_q <= 1'b0;
      redirectPc_q    <= '0;
      execValid_q     <= 1'b0;
      exec_q          <= '0;
    end else begin
      iqMem_q         <= iqMem_d;
      iqHead_q        <= iqHead_d;
      iqTail_q        <= iqTail_d;
      iqCount_q       <= iqCount_d;
      fetchReady_q    <= fetchReady_d;
      mapValid_q      <= mapValid_d;
      mapTag_q        <= mapTag_d;
      live_q          <= live_d;
      predTbl_q       <= predTbl_d;
      bht_q           <= bht_d;
      mispPend_q      <= mispPend_d;
      mispTag_q       <= mispTag_d;
      dispValid_q     <= dispValid_d;
      disp_q          <= disp_d;
      redirectValid_q <= redirectValid_d;
      redirectPc_q    <= redirectPc_d;
      execValid_q     <= execValid_d;
      exec_q          <= exec_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Correct branches raise no flush, so younger entries retire normally
  cps_cmpl_queue u_cmpl_queue (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .alloc        (canDisp),
    .finishValid  (finishValid),
    .finishTag    (finishReq.tag),
    .finishFlush  (mispNow || finishReq.excp),
    .markValid    (mispNow),
    .markTag      (finishReq.tag),
    .headTag_q    (cqHead),
    .tailTag_q    (cqTail),
    .count_q      (cqCount),
    .wrongPath_q  (cqWrong),
    .retireCnt_q  (retireCnt),
    .retireTag0_q (retireTag0),
    .retireTag1_q (retireTag1),
    .purge_q      (purge)
  );
endmodule
`default_nettype wire

// File: tb/cps_seq_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module cps_seq_asserts (
  input wire logic                         core_clk,
  input wire logic                         rst_n,
  input wire logic                         branchPredictEnable,
  input wire logic [cps_pkg::NUM_ISSQ-1:0] issueQueueFree,
  input wire logic                         dispValid_q,
  input wire cps_pkg::cps_disp_t           disp_q,
  input wire logic                         issueValid,
  input wire cps_pkg::cps_issue_t          issueReq,
  input wire logic                         execValid_q,
  input wire cps_pkg::cps_exec_t           exec_q,
  input wire logic                         finishValid,
  input wire cps_pkg::cps_finish_t         finishReq,
  input wire logic                         redirectValid_q,
  input wire logic [cps_pkg::PC_W-1:0]     redirectPc_q,
  input wire logic [1:0]                   retireCnt,
  input wire logic [cps_pkg::TAG_W-1:0]    retireTag0,
  input wire logic [cps_pkg::TAG_W-1:0]    retireTag1,
  input wire logic                         purge
);
  logic [3:0]  retNext_d, retNext_q, dispNext_d, dispNext_q;
  logic [15:0] fin_d, fin_q;
  logic [3:0]  free_q;

  ////////////////////////////////////////////////////////////
  // Tag counters restart at zero, since a purge empties the queue
  always_comb begin
    retNext_d = purge ? 4'h0 : retNext_q + {2'h0, retireCnt};
    dispNext_d = purge ? 4'h0 : dispNext_q + {3'h0, dispValid_q};
    fin_d = fin_q;
    if (finishValid) fin_d[finishReq.tag] = 1'b1;
    if (retireCnt != 2'h0) fin_d[retireTag0] = 1'b0;
    if (retireCnt == 2'h2) fin_d[retireTag1] = 1'b0;
    if (purge) fin_d = 16'h0;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      retNext_q <= 4'h0;
      dispNext_q <= 4'h0;
      fin_q <= 16'h0;
      free_q <= 4'h0;
    end else begin
      retNext_q <= retNext_d;
      dispNext_q <= dispNext_d;
      fin_q <= fin_d;
      free_q <= issueQueueFree;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_retire_max: assert property (
    retireCnt != 2'h3) else $error("more than two retired");
  chk_retire_seq: assert property (
    retireCnt != 2'h0 |-> retireTag0 == retNext_q)
    else $error("retire out of program order");
  chk_retire_done: assert property (
    retireCnt != 2'h0 |-> fin_q[retireTag0]
      && (retireCnt != 2'h2 || fin_q[retireTag1]))
    else $error("unfinished entry retired");
  chk_pred_off: assert property (
    dispValid_q && !$past(branchPredictEnable) |-> !disp_q.predTaken)
    else $error("taken prediction while disabled");
  chk_taken_fetch: assert property (
    dispValid_q && disp_q.predTaken |->
      redirectValid_q && redirectPc_q == disp_q.instr.target)
    else $error("predicted taken without fetch redirect");
  chk_miss_redirect: assert property (
    redirectValid_q && !(dispValid_q && disp_q.predTaken) |->
      $past(finishValid && finishReq.isBranch) && redirectPc_q ==
      ($past(finishReq.taken) ? $past(finishReq.target)
                              : $past(finishReq.pc) + 32'h0000_0004))
    else $error("redirect without branch resolution");
  chk_exec_route: assert property (
    execValid_q |-> $past(issueValid) && exec_q.tag == $past(issueReq.tag)
      && exec_q.unit == $past(issueReq.unit)
      && exec_q.srcTag == $past(issueReq.srcTag)
      && (!exec_q.srcFromRename || ($past(issueReq.srcRenamed)
                                    && $past(fin_q[issueReq.srcTag]))))
    else $error("execution routing wrong");
  chk_disp_room: assert property (
    dispValid_q |-> free_q[disp_q.instr.issueSel])
    else $error("dispatch into full issue queue");
  chk_disp_tag: assert property (
    dispValid_q |-> disp_q.tag == dispNext_q)
    else $error("completion entry not allocated in order");
  chk_purge_stop: assert property (
    purge |=> !dispValid_q) else $error("dispatch right after purge");

  cover property (dispValid_q && disp_q.predTaken);
  cover property (purge);
  cover property (retireCnt != 2'h0 && execValid_q);
  cover property (execValid_q && exec_q.srcFromRename);
endmodule

bind cps_pipeline_sequencer cps_seq_asserts u_chk (
  .core_clk(core_clk), .rst_n(rst_n),
  .branchPredictEnable(branchPredictEnable),
  .issueQueueFree(issueQueueFree), .dispValid_q(dispValid_q),
  .disp_q(disp_q), .issueValid(issueValid), .issueReq(issueReq),
  .execValid_q(execValid_q), .exec_q(exec_q),
  .finishValid(finishValid), .finishReq(finishReq),
  .redirectValid_q(redirectValid_q), .redirectPc_q(redirectPc_q),
  .retireCnt(retireCnt), .retireTag0(retireTag0),
  .retireTag1(retireTag1), .purge(purge));
`default_nettype wire

// File: tb/cps_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module cps_far_model (
  input wire logic            core_clk,
  input wire logic            rst_n,
  input wire logic            dispValid_q,
  input wire cps_pkg::cps_disp_t disp_q,
  input wire logic            execValid_q,
  input wire cps_pkg::cps_exec_t exec_q,
  input wire logic            purge,
  input wire integer          lat,
  input wire logic            takeAll,
  output var logic            issueValid,
  output var cps_pkg::cps_issue_t issueReq,
  output var logic            finishValid,
  output var cps_pkg::cps_finish_t finishReq
);
  cps_pkg::cps_disp_t mem [16];
  cps_pkg::cps_disp_t d;
  logic [3:0]         q [$];
  int                 waitC;

  initial begin
    issueValid = 1'b0;
    finishValid = 1'b0;
    issueReq = '0;
    finishReq = '0;
  end
  ////////////////////////////////////////////////////////////
  // Idle lines flip every cycle so stale values never look valid
  always @(posedge core_clk) begin
    #1;
    finishValid = rst_n && !purge && execValid_q;
    issueValid = rst_n && !purge && q.size() != 0 && waitC >= lat;
    if (!rst_n || purge) begin
      q.delete();
      waitC = 0;
    end
    if (finishValid) begin
      d = mem[exec_q.tag];
      finishReq = '{exec_q.tag, d.instr.isBranch,
                    takeAll | d.predTaken, d.instr.pc, d.instr.target, 1'b0};
    end else finishReq = ~finishReq;
    if (issueValid) begin
      d = mem[q.pop_front()];
      issueReq = '{d.tag, 3'(d.instr.issueSel), d.srcRenamed, d.srcTag};
      waitC = 0;
    end else begin
      issueReq = ~issueReq;
      if (q.size() != 0) waitC++;
    end
    if (rst_n && !purge && dispValid_q) begin
      mem[disp_q.tag] = disp_q;
      q.push_back(disp_q.tag);
    end
  end
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic                 core_clk, rst_n, branchPredictEnable, fetchValid;
  cps_pkg::cps_instr_t  fetchInstr;
  logic                 fetchReady_q, redirectValid_q, dispValid_q;
  logic [31:0]          redirectPc_q, lastPc;
  logic [3:0]           issueQueueFree, retireTag0, retireTag1;
  cps_pkg::cps_disp_t   disp_q;
  logic                 issueValid, execValid_q, finishValid, purge;
  cps_pkg::cps_issue_t  issueReq;
  cps_pkg::cps_exec_t   exec_q;
  cps_pkg::cps_finish_t finishReq;
  logic [1:0]           retireCnt;
  logic                 takeAll, brPred;
  logic [3:0]           retQ [$];
  int lat, nDisp = 0, nRet = 0, nRedir = 0, nPurge = 0;
  int mismatches = 0, tests_run = 0;

  cps_pipeline_sequencer #(.IQ_DEPTH(4)) dut (
    .core_clk(core_clk), .rst_n(rst_n),
    .branchPredictEnable(branchPredictEnable), .fetchValid(fetchValid),
    .fetchInstr(fetchInstr), .fetchReady_q(fetchReady_q),
    .redirectValid_q(redirectValid_q), .redirectPc_q(redirectPc_q),
    .issueQueueFree(issueQueueFree), .dispValid_q(dispValid_q),
    .disp_q(disp_q), .issueValid(issueValid), .issueReq(issueReq),
    .execValid_q(execValid_q), .exec_q(exec_q),
    .finishValid(finishValid), .finishReq(finishReq),
    .retireCnt(retireCnt), .retireTag0(retireTag0),
    .retireTag1(retireTag1), .purge(purge));
  cps_far_model far (
    .core_clk(core_clk), .rst_n(rst_n), .dispValid_q(dispValid_q),
    .disp_q(disp_q), .execValid_q(execValid_q), .exec_q(exec_q),
    .purge(purge), .lat(lat), .takeAll(takeAll),
    .issueValid(issueValid), .issueReq(issueReq),
    .finishValid(finishValid), .finishReq(finishReq));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (dispValid_q === 1'b1) nDisp++;
    if (dispValid_q === 1'b1 && disp_q.instr.isBranch)
      brPred = disp_q.predTaken;
    if (redirectValid_q === 1'b1) nRedir++;
    if (redirectValid_q === 1'b1) lastPc = redirectPc_q;
    if (purge === 1'b1) nPurge++;
    if (retireCnt != 2'h0) retQ.push_back(retireTag0);
    if (retireCnt == 2'h2) retQ.push_back(retireTag1);
    nRet += retireCnt;
  end
  ////////////////////////////////////////////////////////////
  task automatic test_done();
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic tmo();
    mismatches++;
    $display("[ERR] %0t wait ran out", $time);
    test_done();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, string m);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  function automatic cps_pkg::cps_instr_t mk(input logic [31:0] pc,
      input logic br, input logic [4:0] opt, input logic [1:0] sel);
    // Each instruction reads what the one before it wrote
    mk = '{pc, pc + 32'h0000_0040, br, opt, sel, 5'h03, 1'b1, 5'h03, 1'b1};
  endfunction
  // Holds the offer until an edge sees ready without a redirect
  task automatic fetch(input cps_pkg::cps_instr_t i);
    int n;
    fetchInstr = i;
    fetchValid = 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge core_clk);
      if (fetchReady_q === 1'b1 && redirectValid_q !== 1'b1) break;
    end
    #1;
    if (n == 400) tmo();
  endtask
  task automatic idle();
    fetchValid = 1'b0;
    fetchInstr = ~fetchInstr;
  endtask
  task automatic waitc(ref int c, input int n);
    int k;
    for (k = 0; k < 1000 && c < n; k++) begin
      @(posedge core_clk);
      #1;
    end
    if (k == 1000) tmo();
  endtask
  task automatic t_order();
    for (int i = 0; i < 5; i++)
      fetch(mk(32'h1000 + 4 * i, 1'b0, 5'h00, 2'(i)));
    idle();
    waitc(nRet, 5);
    for (int i = 0; i < 5; i++) chk(retQ[i], i, "retire order");
    chk(nDisp, 5, "dispatch count");
  endtask
  task automatic t_stall();
    int d0 = nDisp;
    int r0 = nRet;
    issueQueueFree = 4'he;
    for (int i = 0; i < 4; i++) fetch(mk(32'h2000 + 4 * i, 1'b0, 5'h00, 2'h0));
    idle();
    repeat (10) @(posedge core_clk);
    #1;
    chk(nDisp - d0, 0, "dispatch into full queue");
    chk(fetchReady_q, 0, "ready with full instruction queue");
    issueQueueFree = 4'hf;
    waitc(nRet, r0 + 4);
    chk(nRet - r0, 4, "stalled work lost");
  endtask
  task automatic t_cqfull();
    int d0 = nDisp;
    int r0 = nRet;
    lat = 5000;
    for (int i = 0; i < 20; i++)
      fetch(mk(32'h3000 + 4 * i, 1'b0, 5'h00, 2'(i)));
    idle();
    repeat (10) @(posedge core_clk);
    #1;
    chk(nDisp - d0, 16, "completion queue overfilled");
    lat = 0;
    waitc(nRet, r0 + 20);
  endtask
  task automatic t_pred();
    int p0;
    int r0;
    branchPredictEnable = 1'b0;
    takeAll = 1'b1;
    for (int i = 0; i < 3; i++) begin
      p0 = nPurge;
      fetch(mk(32'h100, 1'b1, 5'(i * 15), 2'h1));
      idle();
      waitc(nPurge, p0 + 1);
      chk(brPred, 0, "taken prediction while disabled");
      chk(lastPc, 32'h140, "redirect target");
    end
    branchPredictEnable = 1'b1;
    for (int i = 0; i < 2; i++) begin
      p0 = nPurge;
      r0 = nRet;
      fetch(mk(32'h100, 1'b1, 5'(i * 17), 2'h1));
      idle();
      waitc(nRedir, nRedir + 1);
      fetch(mk(32'h140, 1'b0, 5'h00, 2'h2));
      fetch(mk(32'h144, 1'b0, 5'h00, 2'h3));
      idle();
      waitc(nRet, r0 + 3);
      chk(brPred, 1, "trained branch not taken");
      chk(nPurge - p0, 0, "purge after correct prediction");
    end
  endtask
  task automatic t_miss();
    int p0 = nPurge;
    int r0 = nRet;
    lat = 2;
    fetch(mk(32'h204, 1'b1, 5'h00, 2'h1));
    for (int i = 0; i < 3; i++) fetch(mk(32'h208 + 4 * i, 1'b0, 5'h00, 2'h0));
    idle();
    waitc(nRedir, nRedir + 1);
    // Right-path instruction offered while the purge is still pending
    fetch(mk(32'h244, 1'b0, 5'h00, 2'h2));
    idle();
    waitc(nPurge, p0 + 1);
    waitc(nRet, r0 + 2);
    repeat (8) @(posedge core_clk);
    #1;
    chk(lastPc, 32'h244, "mispredict redirect");
    chk(nRet - r0, 2, "wrong path retired or refetch lost");
  endtask

  initial begin
    rst_n = 1'b0;
    fetchValid = 1'b0;
    fetchInstr = '0;
    issueQueueFree = 4'hf;
    branchPredictEnable = 1'b1;
    takeAll = 1'b0;
    lat = 0;
    repeat (20) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    @(posedge core_clk);
    #1;
    chk(fetchReady_q, 1, "not ready after reset");
    t_order();
    t_stall();
    t_cqfull();
    t_pred();
    t_miss();
    test_done();
  end
endmodule
`default_nettype wire
